// ### common/pdcap_regs.svh
// register map, field positions, reset values and timing counts
// assumes a 200 mhz apb clock and a protocol layer on the same clock
//
// How it works
// - a caps message holds the 5 v object plus at most 6 more
// - object 0 is always the fixed 5 v supply object
// - further fixed objects follow in rising voltage order
// - battery objects then variable objects, each by rising minimum voltage
// - bits 31:30 give type: 00 fixed, 01 battery, 10 variable, 11 reserved
// - every power data object is one 32-bit word
// - the object count sent equals the words that follow
// - after reset, hard reset or attach, advertise on every timer expiry
// - repeat advertising up to the configured count until acknowledged
// - otherwise send source caps only on request, reserve withdraw, power reclaim or power change when ready
// - a dual-role port advertises as source and answers source cap requests
// - a dual-role port answers sink cap requests in either role
// - one object per type and voltage, carrying the highest current
// - an accessory sink sourcing vconn offers 5 v with zero current first
// - reserve lent to giveback sink: send wait, gotomin, then fresh caps
// - withdrawing a reserve is announced by new source caps
// - only object 0 carries flags; other fixed objects clear bits 29:22
// - no offer or lowest power state: 5 v and zero current
// - fixed object flags sit in bits 29:24, bits 23:22 are zero
// - fixed object voltage sits in bits 19:10 in 50 mv units
// - fixed object maximum current sits in bits 9:0 in 10 ma units
// - every offered current is capped at receptacle and plug limit
// - the dual-role flag follows power role swap support, held fixed
`ifndef PDCAP_REGS_SVH
`define PDCAP_REGS_SVH

`define REG_CTRL 8'h00
`define REG_FLAGS 8'h04
`define REG_LIMIT 8'h08
`define REG_COUNT 8'h0c
`define REG_STATUS 8'h10
`define TBL_SRC_PAGE 3'h2
`define TBL_SNK_PAGE 3'h3
`define TBL_SNK_BASE 4
`define TBL_DEPTH 14
`define OBJ_MAX 7

`define CTRL_ROLE_SRC 0
`define CTRL_DRP 1
`define CTRL_NO_OFFER 2
`define CTRL_GOTO_LOW 3
`define CTRL_ACC_VCONN 4
`define CTRL_GIVEBACK 5
`define CTRL_WITHDRAW 6
`define CTRL_RESET 6'h00
`define FLAGS_RESET 7'h00
`define LIMIT_RESET 10'h12c
`define COUNT_RESET 7'h11

`define ST_CAPS_LSB 4
`define ST_ORDER_ERR 12
`define ST_RX_BAD 13
`define ST_ADV 16
`define ST_RECLAIM 17

`define PDO_TYPE_MSB 31
`define PDO_TYPE_LSB 30
`define PDO_VSAFE5V 10'h064
`define PDO_CUR_MAX 10'h3ff

`define CLK_PERIOD_NS 5
`define CAPS_TIME_NS 150000
`define CAPS_COUNT_DEF 50

`endif

// ### common/pdcap_pkg.sv
// types shared by the capabilities builder
// assumes pdcap_regs.svh holds the numeric constants
package pdcap_pkg;
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_SEND = 3'b010,
    S_ACK = 3'b100
  } state_e;

  typedef enum logic [1:0] {
    K_SRC = 2'h0,
    K_SNK = 2'h1,
    K_WAIT = 2'h2,
    K_GMIN = 2'h3
  } kind_e;

  typedef enum logic [1:0] {
    T_FIXED = 2'h0,
    T_BATT = 2'h1,
    T_VAR = 2'h2,
    T_RSVD = 2'h3
  } pdo_type_e;
endpackage

// ### core/pdo_pack.sv
// packs one 32-bit power data object from a table entry
// assumes entry layout: type 31:30, max v 29:20, v 19:10, current 9:0
`include "pdcap_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pdo_pack (
  input wire logic [31:0] entry,
  input wire logic first,
  input wire logic zero_cur,
  input wire logic [5:0] flags,
  input wire logic [1:0] peak,
  input wire logic [9:0] cur_cap,
  output logic [31:0] pdo
);
  logic [1:0] typ;
  logic [9:0] cur;
  logic [9:0] volt;

  always_comb begin
    // reserved code is folded to fixed so it never leaves the block
    typ = entry[31:30];
    if (first || typ == pdcap_pkg::T_RSVD) begin
      typ = pdcap_pkg::T_FIXED;
    end
    volt = first ? `PDO_VSAFE5V : entry[19:10];
    cur = (entry[9:0] > cur_cap) ? cur_cap : entry[9:0];
    if (zero_cur) begin
      cur = 10'h000;
    end
    if (typ == pdcap_pkg::T_FIXED) begin
      // flags only on object 0, bits 23:22 always zero
      pdo = {typ, first ? flags : 6'h00, 2'h0, peak, volt, cur};
    end else begin
      pdo = {typ, entry[29:20], volt, cur};
    end
  end
endmodule // pdo_pack
`default_nettype wire

// ### core/pd_caps_builder.sv
// capabilities message builder: apb registers, advertisement, tx framing
// assumes protocol layer events and tx handshake run on pclk
//
// Decided for this implementation: the register offsets and the APB slave port.
`include "pdcap_regs.svh"
`timescale 1ns/1ps
`default_nettype none
module pd_caps_builder #(
  parameter int unsigned CAPS_TIMER_CYC = `CAPS_TIME_NS / `CLK_PERIOD_NS,
  parameter int unsigned CAPS_COUNT_MIN = `CAPS_COUNT_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic hard_reset,
  input wire logic attach,
  input wire logic get_src_cap,
  input wire logic get_snk_cap,
  input wire logic power_changed,
  input wire logic reserve_req,
  input wire logic power_reclaimed,
  output logic tx_valid,
  input wire logic tx_ready,
  output logic [1:0] tx_kind,
  output logic [2:0] tx_ndo,
  output logic [31:0] tx_data,
  output logic tx_last,
  input wire logic tx_goodcrc,
  input wire logic tx_fail,
  input wire logic rx_pdo_valid,
  input wire logic [31:0] rx_pdo,
  output logic rx_pdo_bad
);
  localparam logic [15:0] TIMER_LOAD = 16'(CAPS_TIMER_CYC - 1);
  localparam logic [7:0] CAPS_N = 8'(CAPS_COUNT_MIN);

  // register file
  logic [5:0] ctrl, next_ctrl;
  logic [6:0] flags, next_flags;
  logic [9:0] limit, next_limit;
  logic [6:0] count, next_count;
  logic [31:0] tbl [0:`TBL_DEPTH-1];
  logic [31:0] next_tbl [0:`TBL_DEPTH-1];
  logic rx_bad, next_rx_bad;
  logic [31:0] next_prdata;
  logic next_pslverr;
  logic wr, setup, withdraw;
  logic tbl_hit;
  logic [3:0] tbl_idx;

  // sequencer state
  pdcap_pkg::state_e state, next_state;
  logic [1:0] kind, next_kind;
  logic [2:0] ndo, next_ndo;
  logic [2:0] idx, next_idx;
  logic [31:0] data, next_data;
  logic [3:0] pend, next_pend, pend_set, pend_clr;
  logic adv, next_adv;
  logic [7:0] caps_cnt, next_caps_cnt;
  logic [15:0] timer, next_timer;
  logic reclaim, next_reclaim;
  logic next_rx_pdo_bad;
  logic adv_fire, acked;
  logic [1:0] pick, ld_kind;
  logic [2:0] ld_idx, src_n, snk_n;
  logic [31:0] pack_word;
  logic zero_mode, order_err;

  assign wr = psel && penable && pwrite;
  assign setup = psel && !penable;
  assign pready = 1'b1;
  assign withdraw = wr && paddr == `REG_CTRL && pwdata[`CTRL_WITHDRAW];
  assign tbl_hit = (paddr[7:5] == `TBL_SRC_PAGE ||
                    paddr[7:5] == `TBL_SNK_PAGE) && paddr[4:2] != 3'h7;
  assign tbl_idx = (paddr[7:5] == `TBL_SNK_PAGE) ?
                   4'(paddr[4:2]) + 4'(`TBL_SNK_BASE) + 4'h3 :
                   4'(paddr[4:2]);
  // a zero count still sends the mandatory 5 v object
  assign src_n = (count[2:0] == 3'h0) ? 3'h1 : count[2:0];
  assign snk_n = (count[6:4] == 3'h0) ? 3'h1 : count[6:4];
  assign zero_mode = ctrl[`CTRL_NO_OFFER] || ctrl[`CTRL_GOTO_LOW];

  // ordering check; type code doubles as group rank
  function automatic logic order_bad(input int base, input logic [2:0] n);
    logic bad;
    logic [1:0] pr, r;
    logic [9:0] pv, v;
    bad = 1'b0;
    pr = pdcap_pkg::T_FIXED;
    pv = `PDO_VSAFE5V;
    for (int i = 1; i < `OBJ_MAX; i++) begin
      if (3'(i) < n) begin
        r = tbl[base + i][31:30];
        v = tbl[base + i][19:10];
        if (r == pdcap_pkg::T_RSVD) begin
          bad = 1'b1;
        end else if (r < pr || (r == pr && v <= pv)) begin
          bad = 1'b1;
        end
        pr = r;
        pv = v;
      end
    end
    return bad;
  endfunction

  // comb process, so a table write re-runs the check; an assign would not
  always_comb begin
    order_err = order_bad(0, src_n) || order_bad(`OBJ_MAX, snk_n);
  end

  always_comb begin
    next_ctrl = ctrl;
    next_flags = flags;
    next_limit = limit;
    next_count = count;
    next_rx_bad = rx_bad;
    for (int i = 0; i < `TBL_DEPTH; i++) begin
      next_tbl[i] = tbl[i];
    end
    next_prdata = prdata;
    next_pslverr = pslverr;
    if (wr) begin
      if (paddr == `REG_CTRL) begin
        // dual-role flag is a static capability, kept once set
        next_ctrl = pwdata[5:0] | {4'h0, ctrl[`CTRL_DRP], 1'b0};
      end else if (paddr == `REG_FLAGS) begin
        next_flags = pwdata[6:0];
      end else if (paddr == `REG_LIMIT) begin
        next_limit = pwdata[9:0];
      end else if (paddr == `REG_COUNT) begin
        next_count = {pwdata[6:4], 1'b0, pwdata[2:0]};
      end else if (paddr == `REG_STATUS && pwdata[`ST_RX_BAD]) begin
        next_rx_bad = 1'b0;
      end else if (tbl_hit) begin
        next_tbl[tbl_idx] = pwdata;
      end
    end
    // a fresh bad object wins over a clear in the same cycle
    if (rx_pdo_valid && rx_pdo[31:30] == pdcap_pkg::T_RSVD) begin
      next_rx_bad = 1'b1;
    end
    // read data is latched in setup so it comes from a flop
    if (setup) begin
      next_pslverr = 1'b0;
      next_prdata = 32'h0;
      if (paddr == `REG_CTRL) begin
        next_prdata = {26'h0, ctrl};
      end else if (paddr == `REG_FLAGS) begin
        next_prdata = {25'h0, flags};
      end else if (paddr == `REG_LIMIT) begin
        next_prdata = {22'h0, limit};
      end else if (paddr == `REG_COUNT) begin
        next_prdata = {25'h0, count};
      end else if (paddr == `REG_STATUS) begin
        next_prdata = {14'h0, reclaim, adv, 2'h0, rx_bad, order_err,
                       caps_cnt, 1'b0, state};
      end else if (tbl_hit) begin
        next_prdata = tbl[tbl_idx];
      end else begin
        next_pslverr = 1'b1;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= `CTRL_RESET;
      flags <= `FLAGS_RESET;
      limit <= `LIMIT_RESET;
      count <= `COUNT_RESET;
      rx_bad <= 1'b0;
      prdata <= 32'h0;
      pslverr <= 1'b0;
      for (int i = 0; i < `TBL_DEPTH; i++) begin
        tbl[i] <= 32'h0;
      end
    end else begin
      ctrl <= next_ctrl;
      flags <= next_flags;
      limit <= next_limit;
      count <= next_count;
      rx_bad <= next_rx_bad;
      prdata <= next_prdata;
      pslverr <= next_pslverr;
      for (int i = 0; i < `TBL_DEPTH; i++) begin
        tbl[i] <= next_tbl[i];
      end
    end
  end

  // object packer, fed with the word to load next
  pdo_pack u_pack (
    .entry(tbl[(ld_kind == pdcap_pkg::K_SNK) ? 4'(ld_idx) + 4'h7 :
                                                4'(ld_idx)]),
    .first(ld_idx == 3'h0),
    .zero_cur((ld_kind == pdcap_pkg::K_SRC && zero_mode) ||
              (ld_kind == pdcap_pkg::K_SNK && ld_idx == 3'h0 &&
               ctrl[`CTRL_ACC_VCONN])),
    .flags({ctrl[`CTRL_DRP], flags[4:0]}),
    .peak(flags[6:5]),
    .cur_cap(ld_kind == pdcap_pkg::K_SRC ? limit : `PDO_CUR_MAX),
    .pdo(pack_word)
  );

  assign tx_valid = state == pdcap_pkg::S_SEND;
  assign tx_kind = kind;
  assign tx_ndo = ndo;
  assign tx_data = data;
  assign tx_last = ndo == 3'h0 || idx == ndo - 3'h1;
  assign adv_fire = adv && ctrl[`CTRL_ROLE_SRC] && timer == 16'h0;
  assign acked = state == pdcap_pkg::S_ACK && tx_goodcrc;

  always_comb begin
    pend_set = 4'h0;
    if (adv_fire && caps_cnt < CAPS_N) begin
      pend_set[pdcap_pkg::K_SRC] = 1'b1;
    end
    if (get_src_cap) begin
      pend_set[pdcap_pkg::K_SRC] = 1'b1;
    end
    if (power_changed && !adv && ctrl[`CTRL_ROLE_SRC]) begin
      pend_set[pdcap_pkg::K_SRC] = 1'b1;
    end
    if (withdraw || (reclaim && power_reclaimed)) begin
      pend_set[pdcap_pkg::K_SRC] = 1'b1;
    end
    if (get_snk_cap && (ctrl[`CTRL_DRP] || !ctrl[`CTRL_ROLE_SRC])) begin
      pend_set[pdcap_pkg::K_SNK] = 1'b1;
    end
    if (reserve_req && ctrl[`CTRL_GIVEBACK]) begin
      pend_set[pdcap_pkg::K_WAIT] = 1'b1;
      pend_set[pdcap_pkg::K_GMIN] = 1'b1;
    end
    // wait first, then gotomin, then caps
    if (pend[pdcap_pkg::K_WAIT]) begin
      pick = pdcap_pkg::K_WAIT;
    end else if (pend[pdcap_pkg::K_GMIN]) begin
      pick = pdcap_pkg::K_GMIN;
    end else if (pend[pdcap_pkg::K_SRC]) begin
      pick = pdcap_pkg::K_SRC;
    end else begin
      pick = pdcap_pkg::K_SNK;
    end
  end

  always_comb begin
    next_state = state;
    next_kind = kind;
    next_ndo = ndo;
    next_idx = idx;
    next_data = data;
    pend_clr = 4'h0;
    ld_kind = kind;
    ld_idx = idx + 3'h1;
    unique case (state)
      pdcap_pkg::S_IDLE: begin
        ld_kind = pick;
        ld_idx = 3'h0;
        if (pend != 4'h0) begin
          pend_clr[pick] = 1'b1;
          next_kind = pick;
          next_idx = 3'h0;
          next_state = pdcap_pkg::S_SEND;
          if (pick == pdcap_pkg::K_SRC) begin
            next_ndo = zero_mode ? 3'h1 : src_n;
          end else if (pick == pdcap_pkg::K_SNK) begin
            next_ndo = snk_n;
          end else begin
            next_ndo = 3'h0;
          end
          next_data = (pick == pdcap_pkg::K_SRC ||
                       pick == pdcap_pkg::K_SNK) ? pack_word : 32'h0;
        end
      end
      pdcap_pkg::S_SEND: begin
        if (tx_ready) begin
          if (tx_last) begin
            next_state = pdcap_pkg::S_ACK;
          end else begin
            next_idx = idx + 3'h1;
            next_data = pack_word;
          end
        end
      end
      pdcap_pkg::S_ACK: begin
        // no retry here; advertisement repeats on the timer
        if (tx_goodcrc || tx_fail) begin
          next_state = pdcap_pkg::S_IDLE;
        end
      end
      default: begin
        next_state = pdcap_pkg::S_IDLE;
      end
    endcase
    next_pend = (pend & ~pend_clr) | pend_set;
  end

  always_comb begin
    next_adv = adv;
    next_caps_cnt = caps_cnt;
    next_timer = timer;
    next_reclaim = reclaim;
    if (adv && ctrl[`CTRL_ROLE_SRC]) begin
      next_timer = (timer == 16'h0) ? TIMER_LOAD : timer - 16'h1;
      if (adv_fire) begin
        if (caps_cnt < CAPS_N) begin
          next_caps_cnt = caps_cnt + 8'h1;
        end else begin
          next_adv = 1'b0;
        end
      end
    end
    if (acked && kind == pdcap_pkg::K_SRC) begin
      next_adv = 1'b0;
    end
    if (acked && kind == pdcap_pkg::K_GMIN) begin
      next_reclaim = 1'b1;
    end else if (power_reclaimed) begin
      next_reclaim = 1'b0;
    end
    if (hard_reset || attach) begin
      next_adv = 1'b1;
      next_caps_cnt = 8'h0;
      next_timer = TIMER_LOAD;
    end
    next_rx_pdo_bad = rx_pdo_valid &&
                      rx_pdo[31:30] == pdcap_pkg::T_RSVD;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= pdcap_pkg::S_IDLE;
      kind <= pdcap_pkg::K_SRC;
      ndo <= 3'h0;
      idx <= 3'h0;
      data <= 32'h0;
      pend <= 4'h0;
      adv <= 1'b1;
      caps_cnt <= 8'h0;
      timer <= 16'h0;
      reclaim <= 1'b0;
      rx_pdo_bad <= 1'b0;
    end else begin
      state <= next_state;
      kind <= next_kind;
      ndo <= next_ndo;
      idx <= next_idx;
      data <= next_data;
      pend <= next_pend;
      adv <= next_adv;
      caps_cnt <= next_caps_cnt;
      timer <= next_timer;
      reclaim <= next_reclaim;
      rx_pdo_bad <= next_rx_pdo_bad;
    end
  end

  logic caps_beat;
  assign caps_beat = tx_valid && (kind == pdcap_pkg::K_SRC ||
                                  kind == pdcap_pkg::K_SNK);

  chk_first_object: assert property (@(posedge pclk) disable iff (!presetn)
    caps_beat && idx == 3'h0 |-> data[31:30] == 2'h0 &&
    data[19:10] == `PDO_VSAFE5V) else $error("first object not fixed 5 v");
  chk_type_legal: assert property (@(posedge pclk) disable iff (!presetn)
    caps_beat |-> data[31:30] != pdcap_pkg::T_RSVD)
    else $error("reserved object type sent");
  chk_count_range: assert property (@(posedge pclk) disable iff (!presetn)
    caps_beat |-> tx_ndo >= 3'h1 && tx_ndo <= 3'h7)
    else $error("object count out of range");
  chk_count_match: assert property (@(posedge pclk) disable iff (!presetn)
    caps_beat && tx_ready && tx_last |-> idx + 3'h1 == tx_ndo)
    else $error("object count differs from words sent");
  chk_flags_clear: assert property (@(posedge pclk) disable iff (!presetn)
    caps_beat && idx != 3'h0 && data[31:30] == 2'h0 |-> data[29:22] == 8'h0)
    else $error("flags on a later fixed object");
  chk_zero_offer: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && kind == pdcap_pkg::K_SRC && zero_mode |->
    tx_ndo == 3'h1 && data[9:0] == 10'h0) else $error("zero offer wrong");
  chk_current_cap: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && kind == pdcap_pkg::K_SRC && $stable(limit) |->
    data[9:0] <= limit) else $error("offered current above limit");
  chk_adv_repeat: assert property (@(posedge pclk) disable iff (!presetn)
    adv_fire && caps_cnt < CAPS_N |=> pend[pdcap_pkg::K_SRC] ||
    $past(state) == pdcap_pkg::S_IDLE) else $error("advert not queued");
  chk_reserve_wait: assert property (@(posedge pclk) disable iff (!presetn)
    reserve_req && ctrl[`CTRL_GIVEBACK] && state != pdcap_pkg::S_IDLE |=>
    pend[pdcap_pkg::K_WAIT] && pend[pdcap_pkg::K_GMIN])
    else $error("reserve reclaim not queued");
  chk_tx_hold: assert property (@(posedge pclk) disable iff (!presetn)
    tx_valid && !tx_ready |=> tx_valid && $stable(tx_data) && $stable(idx))
    else $error("tx word changed while stalled");
  chk_rx_flag: assert property (@(posedge pclk) disable iff (!presetn)
    rx_pdo_valid && rx_pdo[31:30] == 2'h3 |=> rx_pdo_bad && rx_bad)
    else $error("reserved rx object not flagged");

  cov_src_caps: cover property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_ready && tx_last && kind == pdcap_pkg::K_SRC);
  cov_snk_caps: cover property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_ready && tx_last && kind == pdcap_pkg::K_SNK);
  cov_wait_sent: cover property (@(posedge pclk) disable iff (!presetn)
    tx_valid && tx_ready && kind == pdcap_pkg::K_WAIT);
  cov_adv_done: cover property (@(posedge pclk) disable iff (!presetn)
    acked && kind == pdcap_pkg::K_SRC && adv);
endmodule // pd_caps_builder
`default_nettype wire

// ### tb/pd_partner.sv
// far-end port model: takes message beats, answers goodcrc or fail
// assumes the builder's tx handshake, all on pclk
`timescale 1ns/1ps
`default_nettype none
module pd_partner #(
  parameter int WAIT_CYC = 4000
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic stall,
  input wire logic nack,
  input wire logic tx_valid,
  input wire logic tx_last,
  input wire logic [1:0] tx_kind,
  input wire logic [2:0] tx_ndo,
  input wire logic [31:0] tx_data,
  output logic tx_ready,
  output logic tx_goodcrc,
  output logic tx_fail,
  output logic hard_reset
);
  logic [31:0] b [0:7];
  logic [1:0] kind;
  logic [2:0] ndo;
  logic tick;
  logic seen;
  int nb;
  int msgs;
  int wcnt;
  // slow mode: a beat only every other cycle
  assign tx_ready = !stall || tick;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick <= 0;
      seen <= 0;
      nb <= 0;
      msgs <= 0;
      wcnt <= 0;
      tx_goodcrc <= 0;
      tx_fail <= 0;
      hard_reset <= 0;
    end else begin
      tick <= !tick;
      tx_goodcrc <= 0;
      tx_fail <= 0;
      // no caps before the wait timer runs out
      hard_reset <= !seen && wcnt == WAIT_CYC - 1;
      wcnt <= (wcnt == WAIT_CYC - 1) ? 0 : wcnt + 1;
      if (tx_valid && tx_ready) begin
        b[nb[2:0]] <= tx_data;
        nb <= tx_last ? 0 : nb + 1;
        if (tx_last) begin
          // every message is taken in and answered
          msgs <= msgs + 1;
          kind <= tx_kind;
          ndo <= tx_ndo;
          seen <= seen || tx_kind == 2'h0;
          tx_goodcrc <= !nack;
          tx_fail <= nack;
        end
      end
    end
  end
endmodule // pd_partner
`default_nettype wire

// ### tb/tb.sv
// bench for the caps builder: apb host, event pulses, far-end model
// assumes pd_partner on the tx side and checks embedded in the design
`timescale 1ns/1ps
`default_nettype none
module tb;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd, tx_data, rx_pdo;
  logic [5:0] ev;
  logic stall, nack, hard_reset, tx_valid, tx_ready, tx_last;
  logic tx_goodcrc, tx_fail, rx_pdo_valid, rx_pdo_bad;
  logic [1:0] tx_kind;
  logic [2:0] tx_ndo;
  int err_total, tests_run;

  pd_caps_builder #(.CAPS_TIMER_CYC(20), .CAPS_COUNT_MIN(3))
    pd_caps_builder_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .prdata, .pready, .pslverr, .hard_reset, .attach(ev[0]),
    .get_src_cap(ev[1]), .get_snk_cap(ev[2]), .power_changed(ev[3]),
    .reserve_req(ev[4]), .power_reclaimed(ev[5]), .tx_valid, .tx_ready,
    .tx_kind, .tx_ndo, .tx_data, .tx_last, .tx_goodcrc, .tx_fail,
    .rx_pdo_valid, .rx_pdo, .rx_pdo_bad);
  pd_partner #(.WAIT_CYC(40)) pd_partner_i (.pclk, .presetn, .stall,
    .nack, .tx_valid, .tx_last, .tx_kind, .tx_ndo, .tx_data, .tx_ready,
    .tx_goodcrc, .tx_fail, .hard_reset);

  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end

  task automatic end_sim();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic chk(string n, logic [31:0] x, logic [31:0] g);
    tests_run++;
    if (g !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, x, g);
    end
  endtask

  // request held until pready is seen high at an edge
  task automatic apb(logic w, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 64);
    rd = prdata;
    e = pslverr;
    psel <= 0;
    penable <= 0;
    if (pready !== 1'b1) begin
      err_total++;
      end_sim();
    end
  endtask

  task automatic pulse(int i);
    @(posedge pclk);
    ev[i] <= 1;
    @(posedge pclk);
    ev[i] <= 0;
  endtask

  // bounded wait for the next whole message at the far end
  task automatic msg(logic [1:0] k, logic [2:0] nd);
    int m, n;
    m = pd_partner_i.msgs;
    n = 0;
    while (pd_partner_i.msgs == m && n < 300) begin
      @(posedge pclk);
      n++;
    end
    if (pd_partner_i.msgs == m) begin
      err_total++;
      end_sim();
    end
    chk("tx_kind", {30'h0, k}, {30'h0, pd_partner_i.kind});
    chk("tx_ndo", {29'h0, nd}, {29'h0, pd_partner_i.ndo});
  endtask

  task automatic span(int c, int x);
    int m;
    m = pd_partner_i.msgs;
    repeat (c) @(posedge pclk);
    chk("msg count", x, pd_partner_i.msgs - m);
  endtask

  task automatic t_start();
    int n;
    apb(0, 8'h08, 0);
    chk("limit", 32'h12c, rd);
    apb(0, 8'h5c, 0);
    chk("unmapped", 1, {31'h0, e});
    n = 0;
    while (hard_reset !== 1'b1 && n < 200) begin
      @(posedge pclk);
      n++;
    end
    chk("hard reset", 1, {31'h0, hard_reset});
    apb(1, 8'h00, 32'h1);
    span(300, 3);
    pulse(2);
    span(50, 0);
    pulse(0);
    span(300, 3);
    apb(0, 8'h10, 0);
    chk("status", 32'h31, rd);
    nack <= 0;
  endtask

  task automatic t_src();
    apb(1, 8'h40, {2'b00, 10'h0, 10'h064, 10'h0c8});
    apb(1, 8'h44, {2'b00, 10'h0, 10'h0b4, 10'h1f4});
    apb(1, 8'h48, {2'b01, 10'h0f0, 10'h0b4, 10'h0c8});
    apb(1, 8'h60, {2'b00, 10'h0, 10'h064, 10'h096});
    apb(1, 8'h04, 32'h2a);
    apb(1, 8'h0c, 32'h13);
    apb(1, 8'h00, 32'h3);
    stall <= 1;
    pulse(1);
    msg(0, 3);
    chk("obj0", {8'h2a, 4'h1, 10'h064, 10'h0c8}, pd_partner_i.b[0]);
    chk("obj1", {12'h0, 10'h0b4, 10'h12c}, pd_partner_i.b[1] & 32'hffcf_ffff);
    chk("obj2", {2'b01, 10'h0f0, 10'h0b4, 10'h0c8}, pd_partner_i.b[2]);
    stall <= 0;
  endtask

  task automatic t_modes();
    apb(1, 8'h00, 32'h13);
    pulse(2);
    msg(1, 1);
    chk("snk obj0", {10'h064, 10'h0}, pd_partner_i.b[0] & 32'hfffff);
    apb(1, 8'h00, 32'h7);
    pulse(1);
    msg(0, 1);
    chk("zero obj", {12'h0, 10'h064, 10'h0}, pd_partner_i.b[0] & 32'hc00f_ffff);
    apb(1, 8'h00, 32'hb);
    pulse(1);
    msg(0, 1);
    chk("low obj", {12'h0, 10'h064, 10'h0}, pd_partner_i.b[0] & 32'hc00f_ffff);
    apb(1, 8'h00, 32'h23);
    pulse(4);
    msg(2, 0);
    msg(3, 0);
    pulse(5);
    msg(0, 3);
    apb(1, 8'h00, 32'h43);
    msg(0, 3);
    pulse(3);
    msg(0, 3);
  endtask

  task automatic t_rx();
    for (int t = 0; t < 4; t++) begin
      @(posedge pclk);
      rx_pdo_valid <= 1;
      rx_pdo <= {t[1:0], 30'h0};
      @(posedge pclk);
      rx_pdo_valid <= 0;
      @(posedge pclk);
      chk("rx bad", {31'h0, t == 3}, {31'h0, rx_pdo_bad});
    end
    apb(1, 8'h48, {2'b11, 10'h0f0, 10'h0b4, 10'h0c8});
    apb(0, 8'h10, 0);
    chk("status err", 32'h3, {30'h0, rd[13:12]});
    pulse(1);
    msg(0, 3);
    chk("rsvd type", 32'h0, {30'h0, pd_partner_i.b[2][31:30]});
    apb(1, 8'h10, 32'h2000);
    apb(0, 8'h10, 0);
    chk("rx bad clr", 32'h0, {31'h0, rd[13]});
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, ev} = '0;
    {stall, rx_pdo_valid, rx_pdo} = '0;
    nack = 1;
    err_total = 0;
    tests_run = 0;
    presetn = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1;
    t_start();
    t_src();
    t_modes();
    t_rx();
    end_sim();
  end
endmodule // tb
`default_nettype wire
